// ==== hdl/signal_fault_aggregator.sv ====
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module signal_fault_aggregator
   import fault_agg_pkg::*;
#(
   parameter int SEC_TICKS = SEC_CYCLES
) (
   input  wire logic        pclk,         // Register and logic clock.
   input  wire logic        presetn,      // Asynchronous reset, active low.
   input  wire logic        psel,         // APB select.
   input  wire logic        penable,      // APB access phase.
   input  wire logic        pwrite,       // APB write when high.
   input  wire logic [7:0]  paddr,        // APB byte address.
   input  wire logic [31:0] pwdata,       // APB write data.
   output logic      [31:0] prdata,       // APB read data.
   output logic             pready,       // APB ready.
   output logic             pslverr,      // APB error on unmapped address.
   input  wire logic        frame_start,  // One pulse per frame.
   input  wire det_in_s     det,          // Upstream detector outputs.
   input  wire vid_in_s     vid,          // Received video and checksums.
   input  wire logic [1:0]  pin_n,        // Input pins, low when closed.
   output logic [1:0]       fault         // Fault condition outputs.
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                            input logic [9:0]  w);
      logic [15:0] c;
      logic        fb;
      c = crc;
      for (int i = 0; i < 10; i++) begin
         fb = c[15] ^ w[i];
         c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a[7:2] == o[7:2];
   endfunction

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   logic [7:0]  hold    [NUM_FAULTS];
   logic        enable  [NUM_FAULTS];
   logic [23:0] select  [NUM_FAULTS];
   logic [7:0]  vinv_frames;
   logic [6:0]  cksum_thresh;
   logic [31:0] dur;
   logic [7:0]  timer   [NUM_FAULTS];
   logic [1:0]  clr;
   src_flags_s  src;

   // Zero wait states; read data is captured in the setup phase.
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire wr       = access & pwrite;
   wire mapped   = hit(paddr, OFS_CTRL0) | hit(paddr, OFS_SEL0)
                 | hit(paddr, OFS_CTRL1) | hit(paddr, OFS_SEL1)
                 | hit(paddr, OFS_VINV) | hit(paddr, OFS_CKSUM)
                 | hit(paddr, OFS_DUR) | hit(paddr, OFS_SRC_STAT)
                 | hit(paddr, OFS_FLT_STAT);
   wire wr_ctrl0 = wr & hit(paddr, OFS_CTRL0);
   wire wr_ctrl1 = wr & hit(paddr, OFS_CTRL1);
   wire [1:0] wr_ctrl = {wr_ctrl1, wr_ctrl0};
   wire [1:0] wr_sel  = {wr & hit(paddr, OFS_SEL1),
                         wr & hit(paddr, OFS_SEL0)};
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   // A write of one to the clear bit is a single-cycle request.
   assign clr = wr_ctrl & {2{pwdata[CTRL_CLR_BIT]}};

   // Read mux; the status words show live block state.
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, OFS_CTRL0))
         next_prdata = {16'h0000, hold[0], 7'h00, enable[0]};
      if (hit(paddr, OFS_CTRL1))
         next_prdata = {16'h0000, hold[1], 7'h00, enable[1]};
      if (hit(paddr, OFS_SEL0))
         next_prdata = {8'h00, select[0]};
      if (hit(paddr, OFS_SEL1))
         next_prdata = {8'h00, select[1]};
      if (hit(paddr, OFS_VINV))
         next_prdata = {24'h000000, vinv_frames};
      if (hit(paddr, OFS_CKSUM))
         next_prdata = {25'h0000000, cksum_thresh};
      if (hit(paddr, OFS_DUR))
         next_prdata = dur;
      if (hit(paddr, OFS_SRC_STAT))
         next_prdata = {8'h00, src}; // R8
      if (hit(paddr, OFS_FLT_STAT))
         next_prdata = {8'h00, timer[1], timer[0], 6'h00, fault};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= next_prdata;
      end
   end

   // Shared configuration registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vinv_frames  <= VINV_RST;
         cksum_thresh <= CKSUM_OFF;
         dur          <= DUR_RST;
      end else begin
         if (wr & hit(paddr, OFS_VINV))
            vinv_frames <= pwdata[7:0];
         if (wr & hit(paddr, OFS_CKSUM))
            cksum_thresh <= pwdata[6:0];
         if (wr & hit(paddr, OFS_DUR))
            dur <= pwdata;
      end
   end

   // ------------------------------------------------------------------
   // Source flags
   // ------------------------------------------------------------------
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic [7:0] vinv_cnt;
   logic [6:0] ck_cnt  [2];
   logic [15:0] crc_ap;
   logic [15:0] crc_ff;
   logic [27:0] sec_cnt;
   logic [7:0] quiet_cnt [4];
   logic [3:0] quiet;
   logic [3:0] quiet_flag;
   logic [1:0] ck_bad;
   logic [1:0] ck_flag;

   // Pins are asynchronous; two flops before use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 2'b11;
         pin_sync <= 2'b11;
      end else begin
         pin_meta <= pin_n;
         pin_sync <= pin_meta;
      end
   end

   wire vinv_raw  = det.video_absent | det.video_std_mismatch; // R9
   wire vinv_flag = vinv_raw & (vinv_cnt >= vinv_frames);     // R10

   // Counts whole frames of invalid video; any valid instant restarts,
   // so a short switching glitch reaches only a threshold of 0 or 1.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vinv_cnt <= 8'h00;
      end else if (!vinv_raw) begin
         vinv_cnt <= 8'h00; // R10
      end else if (frame_start && vinv_cnt != 8'hff) begin
         vinv_cnt <= vinv_cnt + 8'h01;
      end
   end

   // Running checksums of the full field and of active picture only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_ap <= CRC_SEED;
         crc_ff <= CRC_SEED;
      end else if (vid.field_end) begin
         crc_ap <= CRC_SEED;
         crc_ff <= CRC_SEED;
      end else if (vid.valid) begin
         crc_ff <= crc_step(crc_ff, vid.word); // R11
         if (vid.active)
            crc_ap <= crc_step(crc_ap, vid.word); // R11
      end
   end

   assign ck_bad = {crc_ff != vid.carried_ff, crc_ap != vid.carried_ap};

   // Consecutive bad field counters, one per checksum kind.
   for (genvar k = 0; k < 2; k++) begin : g_ck
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ck_cnt[k] <= 7'h00;
         end else if (vid.field_end) begin
            if (!ck_bad[k])
               ck_cnt[k] <= 7'h00; // R12
            else if (ck_cnt[k] != 7'h7f)
               ck_cnt[k] <= ck_cnt[k] + 7'h01;
         end
      end
      // Zero threshold is the detection_off_setting.
      assign ck_flag[k] = (cksum_thresh != CKSUM_OFF)
                        & (ck_cnt[k] >= cksum_thresh); // R12 R13 R14
   end

   // Seconds tick for the duration monitors.
   wire sec_tick = (sec_cnt == 28'(SEC_TICKS - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sec_cnt <= 28'h0000000;
      else
         sec_cnt <= sec_tick ? 28'h0000000 : sec_cnt + 28'h0000001;
   end

   // Quiet monitors: black, freeze, caption, rating. A monitor restarts
   // whenever its condition breaks, including on every received packet.
   assign quiet = {~det.rating_seen, ~det.caption_seen,
                   det.pic_no_motion, det.pic_at_black}; // R16 R17 R18 R19
   for (genvar q = 0; q < 4; q++) begin : g_quiet
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            quiet_cnt[q] <= 8'h00;
         else if (!quiet[q])
            quiet_cnt[q] <= 8'h00;
         else if (sec_tick && quiet_cnt[q] != 8'hff)
            quiet_cnt[q] <= quiet_cnt[q] + 8'h01;
      end
      assign quiet_flag[q] = quiet[q] & (quiet_cnt[q] >= dur[8*q +: 8]);
   end

   // Assemble the 24 live flags.
   always_comb begin
      src                                = '0;
      src.video_invalid                  = vinv_flag;
      src.audio_loss                     = det.audio_loss;
      src.audio_loss_12                  = det.audio_loss_12;
      src.audio_loss_34                  = det.audio_loss_34;
      src.active_picture_checksum_errors = ck_flag[0]; // R14
      src.full_frame_checksum_errors     = ck_flag[1]; // R14
      src.audio_format_err               = det.audio_format_err;
      src.phase_rev_12                   = det.phase_rev_12;
      src.phase_rev_34                   = det.phase_rev_34;
      src.over_12    = det.chan_over[0] | det.chan_over[1];     // R15
      src.over_34    = det.chan_over[2] | det.chan_over[3];     // R15
      src.silence_12 = det.chan_silent[0] & det.chan_silent[1]; // R15
      src.silence_34 = det.chan_silent[2] & det.chan_silent[3]; // R15
      src.mono_12    = det.chan_mono[0] & det.chan_mono[1];     // R15
      src.mono_34    = det.chan_mono[2] & det.chan_mono[3];     // R15
      src.timecode_loss                  = det.timecode_loss;
      src.source_identifier_loss         = det.source_identifier_loss;
      src.rating_loss                    = quiet_flag[3]; // R19
      src.caption_loss                   = quiet_flag[2]; // R18
      src.input_pin_one                  = ~pin_sync[0]; // R20
      src.input_pin_two                  = ~pin_sync[1]; // R20
      src.picture_freeze                 = quiet_flag[1]; // R17
      src.picture_black                  = quiet_flag[0]; // R16
      src.genlock_invalid = det.genlock_missing
                          | det.genlock_std_mismatch; // R21
   end

   // ------------------------------------------------------------------
   // Fault conditions
   // ------------------------------------------------------------------
   logic [1:0] combined;

   for (genvar f = 0; f < NUM_FAULTS; f++) begin : g_fault // R1
      // Selection is the only place R22 matters: software masks bits.
      assign combined[f] = enable[f] & |(select[f] & src); // R6 R7 R22

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            enable[f] <= 1'b0;
            hold[f]   <= HOLD_RST; // R3
            select[f] <= 24'h000000;
         end else begin
            if (wr_ctrl[f]) begin
               enable[f] <= pwdata[CTRL_EN_BIT];
               hold[f]   <= pwdata[CTRL_HOLD_LSB +: 8];
            end
            if (wr_sel[f])
               select[f] <= pwdata[23:0]; // R7
         end
      end

      // Source activity wins over a clear arriving in the same cycle.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fault[f] <= 1'b0;
            timer[f] <= 8'h00;
         end else if (!enable[f]) begin
            fault[f] <= 1'b0; // R2
            timer[f] <= 8'h00;
         end else if (combined[f]) begin
            fault[f] <= 1'b1; // R4
            timer[f] <= hold[f]; // R23
         end else if (fault[f] && hold[f] == HOLD_LATCH) begin
            if (clr[f])
               fault[f] <= 1'b0; // R5 R24
         end else if (fault[f] && frame_start) begin
            timer[f] <= timer[f] - 8'h01; // R23
            if (timer[f] <= 8'h01)
               fault[f] <= 1'b0; // R5
         end
      end

      AST_DISABLED_QUIET: assert property (
         @(posedge pclk) disable iff (!presetn)
         !enable[f] |=> !fault[f]) // R2
         else $error("Disabled fault condition is active.");

      AST_ACTIVE_HOLDS: assert property (
         @(posedge pclk) disable iff (!presetn)
         combined[f] && !(wr_ctrl[f] && !pwdata[CTRL_EN_BIT])
            |=> fault[f] && timer[f] == $past(hold[f])) // R4 R23
         else $error("Fault not set or timer not reloaded.");

      AST_RISE_HAS_CAUSE: assert property (
         @(posedge pclk) disable iff (!presetn)
         $rose(fault[f]) |-> $past(|(select[f] & src))) // R6
         else $error("Fault rose without a selected source.");

      AST_RELEASE_CAUSE: assert property (
         @(posedge pclk) disable iff (!presetn)
         $fell(fault[f]) && $past(enable[f]) |->
            $past(clr[f] && hold[f] == HOLD_LATCH)
            || $past(frame_start && timer[f] <= 8'h01)) // R5
         else $error("Fault released without clear or expiry.");

      AST_CLEAR_BLOCKED: assert property (
         @(posedge pclk) disable iff (!presetn)
         clr[f] && combined[f] |=> fault[f]) // R24
         else $error("Clear released a fault with active sources.");

      AST_LATCH_STAYS: assert property (
         @(posedge pclk) disable iff (!presetn)
         fault[f] && enable[f] && hold[f] == HOLD_LATCH && !clr[f]
            && !wr_ctrl[f] |=> fault[f]) // R3
         else $error("Latched fault released without a clear.");

      COV_TIMED_RELEASE: cover property (
         @(posedge pclk) disable iff (!presetn)
         fault[f] ##1 !combined[f] [*2] ##1 $fell(fault[f]));
   end

   // ------------------------------------------------------------------
   // Checks on shared logic
   // ------------------------------------------------------------------
   AST_CKSUM_REACH: assert property (
      @(posedge pclk) disable iff (!presetn)
      vid.field_end && ck_bad[0] && cksum_thresh != CKSUM_OFF
         && ck_cnt[0] == cksum_thresh - 7'h01
         && !(wr && hit(paddr, OFS_CKSUM))
         |=> src.active_picture_checksum_errors) // R12
      else $error("Checksum fault missing at threshold.");

   AST_CKSUM_OFF: assert property (
      @(posedge pclk) disable iff (!presetn)
      cksum_thresh == CKSUM_OFF |->
         !src.active_picture_checksum_errors
         && !src.full_frame_checksum_errors) // R13
      else $error("Checksum fault active while detection is off.");

   AST_GOOD_FIELD_RESTART: assert property (
      @(posedge pclk) disable iff (!presetn)
      vid.field_end && !ck_bad[1] |=> ck_cnt[1] == 7'h00) // R12
      else $error("Good field did not restart the count.");

   AST_VINV_DEBOUNCE: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(src.video_invalid) && vinv_frames != 8'h00
         |-> $past(vinv_raw)) // R10
      else $error("Video invalid rose without an ongoing episode.");

   AST_STATUS_READ: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup && hit(paddr, OFS_SRC_STAT)
         |=> prdata[23:0] == $past(src)) // R8
      else $error("Source status read is not the live flags.");

   COV_CLEAR_LATCHED: cover property (
      @(posedge pclk) disable iff (!presetn)
      fault[0] && hold[0] == HOLD_LATCH && clr[0] ##1 !fault[0]);

   COV_CKSUM_FAULT: cover property (
      @(posedge pclk) disable iff (!presetn)
      $rose(src.full_frame_checksum_errors));

   COV_BOTH_FAULTS: cover property (
      @(posedge pclk) disable iff (!presetn)
      fault == 2'b11);

endmodule
`default_nettype wire

// ==== hdl/fault_agg_pkg.sv ====
// What this block does
// (R1) Two independent fault conditions with identical controls and behaviour.
// (R2) A disabled fault condition keeps its output inactive.
// (R3) Hold setting: latched until cleared, or 1 to 255 frames; default 30.
// (R4) Fault stays asserted while enabled and its combined sources are active.
// (R5) After sources drop, fault holds until clear or hold timer expiry.
// (R6) Combined source is the OR of all selected source flags.
// (R7) Each condition has 24 independently settable source select bits.
// (R8) Live state of every source flag is readable by software.
// (R9) Video invalid means video absent or not matching configured standard.
// (R10) Video invalid is debounced by a programmable minimum frame count.
// (R11) Each field's checksum is computed and compared with the carried one.
// (R12) Checksum fault needs N consecutive bad fields, 1 to 127; good restarts.
// (R13) Threshold off disables checksum faults; threshold one flags any error.
// (R14) Active picture and full frame checksum errors are separate flags.
// (R15) Audio over is either channel; silence and mono need both channels.
// (R16) Picture black: content at or below 7 IRE for programmed seconds.
// (R17) Picture freeze: no activity above noise for programmed seconds.
// (R18) Caption loss: no primary caption data for programmed seconds.
// (R19) Rating loss: no rating packet received for programmed seconds.
// (R20) Each input pin flag is active while its pin is held low.
// (R21) Genlock invalid: reference missing or standard differs from input.
// (R22) Software deselects checksum sources when upstream alters the picture.
// (R23) Hold timer reloads while sources are active, decrements per frame.
// (R24) Clear request releases a latched fault only with sources inactive.
package fault_agg_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ------------------------------------------------------------------
   localparam logic [7:0]  OFS_CTRL0     = 8'h00;
   localparam logic [7:0]  OFS_SEL0      = 8'h04;
   localparam logic [7:0]  OFS_CTRL1     = 8'h08;
   localparam logic [7:0]  OFS_SEL1      = 8'h0c;
   localparam logic [7:0]  OFS_VINV      = 8'h10;
   localparam logic [7:0]  OFS_CKSUM     = 8'h14;
   localparam logic [7:0]  OFS_DUR       = 8'h18;
   localparam logic [7:0]  OFS_SRC_STAT  = 8'h1c;
   localparam logic [7:0]  OFS_FLT_STAT  = 8'h20;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_HOLD_LSB = 8;
   localparam int          CTRL_CLR_BIT  = 16;
   localparam logic [7:0]  HOLD_LATCH    = 8'h00;
   localparam logic [7:0]  HOLD_RST      = 8'h1e;
   localparam logic [7:0]  VINV_RST      = 8'h02;
   localparam logic [6:0]  CKSUM_OFF     = 7'h00;
   localparam logic [31:0] DUR_RST       = 32'h3cb40a0a;
   localparam logic [15:0] CRC_POLY      = 16'h1021;
   localparam logic [15:0] CRC_SEED      = 16'hffff;
   localparam int          NUM_FAULTS    = 2;
   localparam int          NUM_SRC       = 24;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ    = 250;
   localparam int SECOND_S   = 1;
   localparam int SEC_CYCLES = SECOND_S * CLK_MHZ * 1000000;

   // Source flags; field order gives bit 0 = video_invalid, 23 = genlock.
   typedef struct packed {
      logic genlock_invalid;
      logic picture_black;
      logic picture_freeze;
      logic input_pin_two;
      logic input_pin_one;
      logic caption_loss;
      logic rating_loss;
      logic source_identifier_loss;
      logic timecode_loss;
      logic mono_34;
      logic mono_12;
      logic silence_34;
      logic silence_12;
      logic over_34;
      logic over_12;
      logic phase_rev_34;
      logic phase_rev_12;
      logic audio_format_err;
      logic full_frame_checksum_errors;
      logic active_picture_checksum_errors;
      logic audio_loss_34;
      logic audio_loss_12;
      logic audio_loss;
      logic video_invalid;
   } src_flags_s;

   // Raw detector levels and pulses, all on pclk.
   typedef struct packed {
      logic       video_absent;
      logic       video_std_mismatch;
      logic       genlock_missing;
      logic       genlock_std_mismatch;
      logic       audio_loss;
      logic       audio_loss_12;
      logic       audio_loss_34;
      logic       audio_format_err;
      logic       phase_rev_12;
      logic       phase_rev_34;
      logic [3:0] chan_over;
      logic [3:0] chan_silent;
      logic [3:0] chan_mono;
      logic       timecode_loss;
      logic       source_identifier_loss;
      logic       pic_at_black;
      logic       pic_no_motion;
      logic       caption_seen;
      logic       rating_seen;
   } det_in_s;

   // Received video words and the checksums carried in the blanking.
   typedef struct packed {
      logic [9:0]  word;
      logic        valid;
      logic        active;
      logic        field_end;
      logic [15:0] carried_ap;
      logic [15:0] carried_ff;
   } vid_in_s;

endpackage

// ==== test/det_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Upstream detector model: registers the bench's requests onto the pins.
// ---------------------------------------------------------------------
module det_model
   import fault_agg_pkg::*;
(
   input  wire logic       pclk,         // Shared clock.
   input  wire logic       presetn,      // Reset, active low.
   input  wire logic       frame_req,    // Bench asks for one frame pulse.
   input  wire det_in_s    det_req,      // Requested detector levels.
   input  wire logic [1:0] pin_req,      // Requested pin levels.
   output var  det_in_s    det,          // Detector outputs.
   output var  vid_in_s    vid,          // Video words, idle.
   output logic            frame_start,  // Frame pulse.
   output logic      [1:0] pin_n         // Pins, pulled up when open.
);
   logic [9:0] pat;
   // No valid words arrive, so both sums stay at the seed. A field ends
   // every 64 cycles, and active picture fails in runs of two fields.
   assign vid = {pat, 2'b00, (pat[5:0] == 6'h3f),
                 (pat[7] ? {6'h00, pat} : CRC_SEED), CRC_SEED};
   // Packets arrive every 64 cycles so the caption and rating timers never run out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         det         <= '0;
         frame_start <= 1'b0;
         pin_n       <= 2'b11;
         pat         <= 10'h000;
      end else begin
         det              <= det_req;
         det.caption_seen <= det_req.caption_seen | (pat[5:0] == 6'h00);
         det.rating_seen  <= det_req.rating_seen | (pat[5:0] == 6'h00);
         frame_start      <= frame_req;
         pin_n            <= pin_req;
         pat              <= pat + 10'h001;
      end
   end
endmodule
`default_nettype wire

// ==== test/signal_fault_aggregator_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module signal_fault_aggregator_bench;
   import fault_agg_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        frame_req, frame_start, err_bit;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  pin_req, pin_n, fault;
   det_in_s     det_req, det;
   vid_in_s     vid;
   int          err_total, total_checks;

   // ------------------------------------------------------------------
   // Design, detector model and clock
   // ------------------------------------------------------------------
   signal_fault_aggregator #(.SEC_TICKS(8)) dut_u (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_start(frame_start), .det(det), .vid(vid),
      .pin_n(pin_n), .fault(fault));
   det_model model_u (.pclk(pclk), .presetn(presetn), .frame_req(frame_req),
      .det_req(det_req), .pin_req(pin_req), .det(det), .vid(vid),
      .frame_start(frame_start), .pin_n(pin_n));
   // Free running 250 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic final_report();
      if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin err_total++; final_report(); end
      rd = prdata;
      err_bit = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Frame pulses come only on request, so hold timing stays exact.
   task automatic frame();
      @(posedge pclk); frame_req <= 1'b1;
      @(posedge pclk); frame_req <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic settle();
      repeat (5) @(posedge pclk);
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; frame_req = 1'b0; det_req = '0;
      pin_req = 2'b11; err_total = 0; total_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(OFS_CTRL0, {16'h0000, HOLD_RST, 8'h00});
      rdchk(OFS_VINV, {24'h000000, VINV_RST});
      rdchk(OFS_CKSUM, 32'h0);
      rdchk(OFS_DUR, DUR_RST);
      apb(1'b0, 8'hfc, 32'h0);
      chk({31'h0, err_bit}, 32'h1);
      // Checksum sources stay deselected here.
      apb(1'b1, OFS_SEL0, 32'h2);
      apb(1'b1, OFS_SEL1, 32'h2);
      apb(1'b1, OFS_CTRL0, 32'h0201);
      det_req.audio_loss <= 1'b1;
      settle();
      chk(32'(fault), 32'h1);
      rdchk(OFS_SRC_STAT, 32'h2);
      frame();
      chk(32'(fault), 32'h1);
      det_req.audio_loss <= 1'b0;
      settle();
      chk(32'(fault), 32'h1);
      frame();
      chk(32'(fault), 32'h1);
      frame();
      chk(32'(fault), 32'h0);
      // Latched hold on the second condition; clear refused while active.
      apb(1'b1, OFS_CTRL1, 32'h0001);
      det_req.audio_loss <= 1'b1;
      settle();
      apb(1'b1, OFS_CTRL1, 32'h10001);
      settle();
      chk(32'(fault), 32'h3);
      det_req.audio_loss <= 1'b0;
      repeat (3) frame();
      chk(32'(fault), 32'h2);
      apb(1'b1, OFS_CTRL1, 32'h10001);
      settle();
      chk(32'(fault), 32'h0);
      rdchk(OFS_CTRL1, 32'h1);
      det_req.audio_loss <= 1'b1;
      apb(1'b1, OFS_CTRL0, 32'h0200);
      settle();
      chk(32'(fault), 32'h2);
      // Live flags of pins, genlock and audio pairs.
      det_req <= '0;
      pin_req <= 2'b10;
      det_req.genlock_missing <= 1'b1;
      det_req.chan_over <= 4'h2;
      det_req.chan_silent <= 4'h1;
      settle();
      rdchk(OFS_SRC_STAT, 32'h880200);
      det_req.chan_silent <= 4'h3;
      settle();
      rdchk(OFS_SRC_STAT, 32'h880a00);
      // Video invalid needs two frames of raw invalid.
      det_req <= '0;
      pin_req <= 2'b11;
      det_req.video_absent <= 1'b1;
      settle();
      frame();
      rdchk(OFS_SRC_STAT, 32'h0);
      frame();
      rdchk(OFS_SRC_STAT, 32'h1);
      det_req.video_absent <= 1'b0;
      settle();
      rdchk(OFS_SRC_STAT, 32'h0);
      // Runs of two bad fields: a threshold of three never trips, two does.
      apb(1'b1, OFS_SEL0, 32'h10);
      apb(1'b1, OFS_CKSUM, 32'h3);
      apb(1'b1, OFS_CTRL0, 32'h0001);
      repeat (512) @(posedge pclk);
      chk(32'(fault[0]), 32'h0);
      apb(1'b1, OFS_CKSUM, 32'h2);
      repeat (512) @(posedge pclk);
      chk(32'(fault[0]), 32'h1);
      apb(1'b1, OFS_CKSUM, 32'h0);
      apb(1'b1, OFS_CTRL0, 32'h10001);
      repeat (512) @(posedge pclk);
      chk(32'(fault[0]), 32'h0);
      rdchk(OFS_FLT_STAT, 32'h2);
      // One second of black picture raises its flag.
      apb(1'b1, OFS_DUR, 32'h3cb40a01);
      det_req.pic_at_black <= 1'b1;
      repeat (20) @(posedge pclk);
      rdchk(OFS_SRC_STAT, 32'h400000);
      final_report();
   end
endmodule
`default_nettype wire
